/* hdl/amux_pkg.sv */
// Register map, field layout and encodings of the detection register bank
package amux_pkg;
  localparam int ADDR_W = 8;
  localparam int DW = 8;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_STATUS = 6'h02;
  localparam logic [5:0] IDX_MASK = 6'h05;
  localparam logic [5:0] IDX_CTRL1 = 6'h06;
  localparam logic [5:0] IDX_ADC1 = 6'h09;
  localparam logic [5:0] IDX_ADC2 = 6'h0A;
  localparam logic [5:0] IDX_OPEN_THR = 6'h0B;
  localparam logic [5:0] IDX_OMTP_THR = 6'h0C;
  localparam logic [5:0] IDX_DEF_A = 6'h0D;
  localparam logic [5:0] IDX_DEF_B = 6'h0E;
  localparam logic [5:0] IDX_RESULT = 6'h10;
  localparam logic [5:0] IDX_DETECT = 6'h11;
  // Reset values
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_CTRL1 = 8'h13;
  localparam logic [7:0] RST_ADC1 = 8'h33;
  localparam logic [7:0] RST_ADC2 = 8'h90;
  localparam logic [7:0] RST_OPEN_THR = 8'h0C;
  localparam logic [7:0] RST_OMTP_THR = 8'h30;
  localparam logic [7:0] RST_DEF_A = 8'h50;
  localparam logic [7:0] RST_DEF_B = 8'h00;
  // Writable bits of registers with reserved bits
  localparam logic [7:0] WMASK_DEF_A = 8'hF7;
  localparam logic [7:0] WMASK_DEF_B = 8'hF3;
  localparam logic [7:0] WMASK_ADC2 = 8'hFC;
  // Field positions
  localparam int STATUS_EOC_BIT = 0;
  localparam int MASK_EOC_BIT = 0;
  localparam int CTRL1_RESTORE_BIT = 3;
  localparam int CTRL1_MODE_LSB = 0;
  localparam int ADC1_LOWZ_BIT = 4;
  localparam int ADC1_DETECTION_CURRENT_LSB = 2;
  localparam int ADC1_CTL_LSB = 0;
  localparam int ADC2_OVTH1_LSB = 6;
  localparam int ADC2_OVTH2_LSB = 4;
  localparam int ADC2_AVG_LSB = 2;
  localparam int ADC2_RELEASE_BIT = 1;
  localparam int ADC2_TRIG_BIT = 0;
  localparam int DEF_A_TOP_LSB = 6;
  localparam int DEF_A_BOT_LSB = 4;
  localparam int DEF_A_SBU_LSB = 0;
  localparam int DEF_B_LEFT_A_BIT = 7;
  localparam int DEF_B_RIGHT_A_BIT = 6;
  localparam int DEF_B_LEFT_B_BIT = 5;
  localparam int DEF_B_RIGHT_B_BIT = 4;
  localparam int DEF_B_TXRX_LSB = 0;
  // Encodings
  localparam logic [1:0] CTL_OFF = 2'h0;
  localparam logic [1:0] CTL_SINGLE = 2'h1;
  localparam logic [1:0] CTL_AVG = 2'h2;
  localparam logic [1:0] CTL_AUTO = 2'h3;
  localparam logic [2:0] MODE_PROG = 3'h3;
  localparam logic [1:0] DETECTION_CURRENT_1P1 = 2'h2;
  localparam logic [1:0] DETECTION_CURRENT_5P5 = 2'h3;
  localparam logic [1:0] SW_DATA = 2'h1;
  localparam logic [1:0] SW_AUDIO = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {ENG_IDLE, ENG_RUN} eng_state_t;
endpackage

/* hdl/conv_if.sv */
// Link between register bank and averaging engine
`timescale 1ns/10ps
`default_nettype none
interface conv_if #(parameter int DW = 8);
  logic start;
  logic [2:0] shift;
  logic sample_valid;
  logic [DW-1:0] sample;
  logic busy;
  logic done;
  logic [DW-1:0] result;
  modport ctrl(output start, shift, sample_valid, sample, input busy, done, result);
  modport engine(input start, shift, sample_valid, sample, output busy, done, result);
endinterface
`default_nettype wire

/* hdl/conv_average.sv */
// Converter sample accumulator and averager
`timescale 1ns/10ps
`default_nettype none
module conv_average #(
  parameter int DW = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Engine side
  conv_if.engine cv
);
  import amux_pkg::*;
  eng_state_t state_q;
  logic [4:0] cnt_q;
  logic [DW+3:0] acc_q;
  logic [2:0] shift_q;
  logic done_q;
  logic [DW-1:0] result_q;
  wire [DW+3:0] acc_nxt = acc_q + {4'h0, cv.sample};
  wire [4:0] last_cnt = 5'((5'h01 << shift_q) - 5'h01);
  wire last = cnt_q == last_cnt;
  wire [DW-1:0] avg = DW'(acc_nxt >> shift_q);
  assign cv.busy = state_q == ENG_RUN;
  assign cv.done = done_q;
  assign cv.result = result_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ENG_IDLE;
      cnt_q <= 5'h00;
      acc_q <= '0;
      shift_q <= 3'h0;
      done_q <= 1'b0;
      result_q <= '0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        ENG_IDLE: begin
          if (cv.start) begin
            acc_q <= '0;
            cnt_q <= 5'h00;
            shift_q <= cv.shift;
            state_q <= ENG_RUN;
          end
        end
        ENG_RUN: begin
          if (cv.sample_valid) begin
            acc_q <= acc_nxt;
            cnt_q <= cnt_q + 5'h01;
            if (last) begin
              result_q <= avg;
              done_q <= 1'b1;
              state_q <= ENG_IDLE;
            end
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* hdl/audio_mux_adc_default_regs.sv */
// Detection control and default switch register bank behind AXI4-Lite
// Function
// - Low-impedance enable bit switches on the low-impedance check enable whenever conversion control is not 00.
// - Manual current field: 00/01 100 uA, 10 1.1 mA, 11 5.5 mA.
// - Conversion control 00 keeps converter and detection inactive.
// - Conversion control 01: trigger starts one single measurement.
// - Conversion control 10: trigger starts an averaged measurement.
// - Conversion control 11: detection runs from the internal state machine.
// - Data path overvoltage threshold field drives data switch threshold.
// - Independent sideband/sense threshold field, same four-level encoding.
// - Averaging count 00..11 selects 2, 4, 8 or 16 samples.
// - Latch release write of 1 restores switches only when restore enabled.
// - Trigger write of 1 starts a measurement only in modes 01 or 10.
// - Manual conversion completion sets end-of-conversion status bit 0.
// - Result compared with open-cable threshold flags an open cable.
// - Result below headset-type threshold reports the alternate headset wiring.
// - Data switch default codes: 00/11 open, 01 data, 10 audio.
// - Sideband default: bit 2 orientation, bits 1 and 0 close paths.
// - Right sense default bits connect right sense lines to ground sense.
// - Left sense default bits connect left sense lines on that variant.
// - Serial pair default: 00/11 off, 01 and 10 opposite routings.
// - Ground-sense connection wins over a conflicting serial pair setting.
// - Default settings act only in programmable default mode 011.
// - End-of-conversion interrupt raised only when its mask bit is 1.
`timescale 1ns/10ps
`default_nettype none
module audio_mux_adc_default_regs #(
  parameter bit HAS_LEFT_SENSE = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // AXI4-Lite write
  input wire logic [amux_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [amux_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter front end
  input wire logic sample_valid,
  input wire logic [amux_pkg::DW-1:0] sample,
  input wire logic fsm_detect_req,
  output logic conv_active,
  output logic current_100ua_en,
  output logic current_1p1ma_en,
  output logic current_5p5ma_en,
  output logic low_impedance_check_en,
  // Protection and interrupt
  output logic [1:0] data_path_ov_threshold,
  output logic [1:0] sideband_path_ov_threshold,
  output logic ov_restore,
  output logic eoc_irq,
  // Detection results
  output logic open_cable,
  output logic headset_alt_wiring,
  // Default switch drive
  output logic [15:0] switch_close
);
  import amux_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] mask_q, ctrl1_q, adc1_q, adc2_q, open_thr_q, omtp_thr_q;
  logic [7:0] def_a_q, def_b_q, result_q;
  logic eoc_q, trig_q, manual_run_q, restore_q, open_q, omtp_q;
  logic [15:0] sw_q;
  logic [3:0] cur_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  conv_if #(.DW(DW)) cv ();

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode
  function automatic logic mapped(input logic [5:0] idx);
    mapped = idx == IDX_STATUS || idx == IDX_MASK || idx == IDX_CTRL1 ||
             idx == IDX_ADC1 || idx == IDX_ADC2 || idx == IDX_OPEN_THR ||
             idx == IDX_OMTP_THR || idx == IDX_DEF_A || idx == IDX_DEF_B ||
             idx == IDX_RESULT || idx == IDX_DETECT;
  endfunction
  wire [5:0] wr_idx = s_axi_awaddr[7:2];
  wire [5:0] rd_idx = s_axi_araddr[7:2];
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  wire wr_en = wr_go && s_axi_wstrb[0];
  wire [7:0] wd = s_axi_wdata[7:0];
  wire rd_go = s_axi_arvalid && !rvalid_q;
  function automatic logic wr_hit(input logic en, input logic [5:0] i, input logic [5:0] r);
    wr_hit = en && i == r;
  endfunction
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // Field views
  wire [1:0] conv_ctl = adc1_q[ADC1_CTL_LSB+:2];
  wire [1:0] detection_current_sel = adc1_q[ADC1_DETECTION_CURRENT_LSB+:2];
  wire [1:0] avg_code = adc2_q[ADC2_AVG_LSB+:2];
  wire [2:0] sw_mode = ctrl1_q[CTRL1_MODE_LSB+:3];
  wire restore_en = ctrl1_q[CTRL1_RESTORE_BIT];
  wire manual_ctl = conv_ctl == CTL_SINGLE || conv_ctl == CTL_AVG;
  wire [7:0] adc2_rd = adc2_q & WMASK_ADC2 | {7'h00, trig_q};
  wire [7:0] status_rd = {7'h00, eoc_q};
  wire [7:0] detect_rd = {6'h00, omtp_q, open_q};
  wire [7:0] rd_val =
    rd_idx == IDX_STATUS ? status_rd :
    rd_idx == IDX_MASK ? mask_q :
    rd_idx == IDX_CTRL1 ? ctrl1_q :
    rd_idx == IDX_ADC1 ? adc1_q :
    rd_idx == IDX_ADC2 ? adc2_rd :
    rd_idx == IDX_OPEN_THR ? open_thr_q :
    rd_idx == IDX_OMTP_THR ? omtp_thr_q :
    rd_idx == IDX_DEF_A ? def_a_q :
    rd_idx == IDX_DEF_B ? def_b_q :
    rd_idx == IDX_RESULT ? result_q :
    rd_idx == IDX_DETECT ? detect_rd : 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // Bus response
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q <= mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      rdata_q <= {24'h00_0000, rd_val};
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Plain read/write registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mask_q <= RST_MASK;
      ctrl1_q <= RST_CTRL1;
      adc1_q <= RST_ADC1;
      adc2_q <= RST_ADC2;
      open_thr_q <= RST_OPEN_THR;
      omtp_thr_q <= RST_OMTP_THR;
      def_a_q <= RST_DEF_A;
      def_b_q <= RST_DEF_B;
    end else begin
      if (wr_hit(wr_en, wr_idx, IDX_MASK)) mask_q <= wd;
      if (wr_hit(wr_en, wr_idx, IDX_CTRL1)) ctrl1_q <= wd;
      if (wr_hit(wr_en, wr_idx, IDX_ADC1)) adc1_q <= wd;
      if (wr_hit(wr_en, wr_idx, IDX_ADC2)) adc2_q <= wd & WMASK_ADC2;
      if (wr_hit(wr_en, wr_idx, IDX_OPEN_THR)) open_thr_q <= wd;
      if (wr_hit(wr_en, wr_idx, IDX_OMTP_THR)) omtp_thr_q <= wd;
      if (wr_hit(wr_en, wr_idx, IDX_DEF_A)) def_a_q <= wd & WMASK_DEF_A;
      if (wr_hit(wr_en, wr_idx, IDX_DEF_B)) def_b_q <= wd & WMASK_DEF_B;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Conversion control
  wire adc2_wr = wr_hit(wr_en, wr_idx, IDX_ADC2);
  wire trig_wr = adc2_wr && wd[ADC2_TRIG_BIT] && manual_ctl;
  wire accept = trig_q && !cv.busy && manual_ctl;
  wire auto_go = conv_ctl == CTL_AUTO && fsm_detect_req && !cv.busy;
  wire [2:0] avg_shift = {1'b0, avg_code} + 3'h1;
  wire manual_done = cv.done && manual_run_q;
  wire status_clr = wr_hit(wr_en, wr_idx, IDX_STATUS) && wd[STATUS_EOC_BIT];
  assign cv.start = accept || auto_go;
  assign cv.shift = accept && conv_ctl == CTL_AVG ? avg_shift : 3'h0;
  assign cv.sample_valid = sample_valid;
  assign cv.sample = sample;

  conv_average #(.DW(DW)) u_avg (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .cv(cv)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      trig_q <= 1'b0;
      manual_run_q <= 1'b0;
    end else begin
      trig_q <= manual_ctl && (trig_wr || trig_q && !accept);
      manual_run_q <= accept || manual_run_q && !cv.done;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      eoc_q <= 1'b0;
      result_q <= 8'h00;
      open_q <= 1'b0;
      omtp_q <= 1'b0;
      restore_q <= 1'b0;
    end else begin
      eoc_q <= manual_done || eoc_q && !status_clr;
      restore_q <= adc2_wr && wd[ADC2_RELEASE_BIT] && restore_en;
      if (cv.done) begin
        result_q <= cv.result;
        open_q <= cv.result > open_thr_q;
        omtp_q <= cv.result < omtp_thr_q;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Current source selection
  wire manual_live = manual_run_q && conv_ctl != CTL_OFF;
  wire [3:0] cur_d = {
    conv_ctl != CTL_OFF && adc1_q[ADC1_LOWZ_BIT],
    manual_live && detection_current_sel == DETECTION_CURRENT_5P5,
    manual_live && detection_current_sel == DETECTION_CURRENT_1P1,
    manual_live && !detection_current_sel[1]
  };
  always_ff @(posedge sys_clk) begin
    if (!rst_n) cur_q <= 4'h0;
    else cur_q <= cur_d;
  end
  assign low_impedance_check_en = cur_q[3];
  assign current_5p5ma_en = cur_q[2];
  assign current_1p1ma_en = cur_q[1];
  assign current_100ua_en = cur_q[0];
  assign conv_active = cv.busy;
  assign data_path_ov_threshold = adc2_q[ADC2_OVTH1_LSB+:2];
  assign sideband_path_ov_threshold = adc2_q[ADC2_OVTH2_LSB+:2];
  assign ov_restore = restore_q;
  assign eoc_irq = eoc_q && mask_q[MASK_EOC_BIT];
  assign open_cable = open_q;
  assign headset_alt_wiring = omtp_q;

  //////////////////////////////////////////////////////////////////////////////
  // Default switch decode
  wire [1:0] top_c = def_a_q[DEF_A_TOP_LSB+:2];
  wire [1:0] bot_c = def_a_q[DEF_A_BOT_LSB+:2];
  wire [2:0] sbu_c = def_a_q[DEF_A_SBU_LSB+:3];
  wire [1:0] txrx_c = def_b_q[DEF_B_TXRX_LSB+:2];
  wire ra = def_b_q[DEF_B_RIGHT_A_BIT];
  wire rb = def_b_q[DEF_B_RIGHT_B_BIT];
  wire la = HAS_LEFT_SENSE && def_b_q[DEF_B_LEFT_A_BIT];
  wire lb = HAS_LEFT_SENSE && def_b_q[DEF_B_LEFT_B_BIT];
  wire tx_b = txrx_c == SW_DATA && !rb;
  wire rx_a = txrx_c == SW_DATA && !ra;
  wire tx_a = txrx_c == SW_AUDIO && !ra;
  wire rx_b = txrx_c == SW_AUDIO && !rb;
  wire [15:0] sw_dec = {
    top_c == SW_DATA, top_c == SW_AUDIO,
    bot_c == SW_DATA, bot_c == SW_AUDIO,
    sbu_c[0] && !sbu_c[2], sbu_c[1] && !sbu_c[2],
    sbu_c[0] && sbu_c[2], sbu_c[1] && sbu_c[2],
    ra, rb, la, lb, tx_b, rx_a, tx_a, rx_b
  };
  wire [15:0] sw_d = sw_mode == MODE_PROG ? sw_dec : 16'h0000;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) sw_q <= 16'h0000;
    else sw_q <= sw_d;
  end
  assign switch_close = sw_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_eoc_on_done: assert property (manual_done |=> eoc_q)
    else $error("end of conversion not flagged");
  a_trig_clears: assert property (accept && !trig_wr |=> !trig_q)
    else $error("trigger not cleared");
  a_trig_mode_gate: assert property (!manual_ctl |=> !trig_q)
    else $error("trigger held outside manual modes");
  a_off_idle: assert property (conv_ctl == CTL_OFF |-> !cv.start ##1 !cur_q[3])
    else $error("converter active while off");
  a_restore_gate: assert property (ov_restore |-> $past(restore_en))
    else $error("restore without enable");
  a_irq_masked: assert property (!mask_q[MASK_EOC_BIT] |-> !eoc_irq)
    else $error("masked interrupt raised");
  a_mode_gate: assert property (sw_mode != MODE_PROG |=> sw_q == 16'h0000)
    else $error("defaults applied outside default mode");
  a_ground_sense_output_wins: assert property (sw_q[7] |-> !sw_q[2] && !sw_q[1])
    else $error("serial pair overrides ground sense");
  a_omtp_cmp: assert property (cv.done |=> omtp_q == ($past(cv.result) < omtp_thr_q))
    else $error("headset compare wrong");
  a_cur_sel: assert property (manual_live && detection_current_sel == DETECTION_CURRENT_1P1 |=> current_1p1ma_en)
    else $error("wrong detection current");
  a_write_resp: assert property (wr_go |=> s_axi_bvalid)
    else $error("write not answered");
  a_lowz_on: assert property (conv_ctl != CTL_OFF && adc1_q[ADC1_LOWZ_BIT] |=> cur_q[3])
    else $error("low impedance sources not enabled");
  a_cur_5p5: assert property (manual_live && detection_current_sel == DETECTION_CURRENT_5P5 |=> current_5p5ma_en)
    else $error("high detection current not selected");
  a_cur_low: assert property (manual_live && !detection_current_sel[1] |=> current_100ua_en)
    else $error("low detection current not selected");
  a_cur_idle: assert property (!manual_live |=> cur_q[2:0] == 3'h0)
    else $error("detection current on while idle");
  a_auto_single: assert property (cv.start && conv_ctl == CTL_AUTO |-> cv.shift == 3'h0)
    else $error("automatic detection not single sample");
  a_avg_depth: assert property (accept && conv_ctl == CTL_AVG |-> cv.shift == avg_code + 2'h1)
    else $error("averaging depth wrong");
  a_manual_only: assert property (!manual_ctl |-> !accept)
    else $error("trigger accepted outside manual modes");
  a_eoc_clear: assert property (status_clr && !manual_done |=> !eoc_q)
    else $error("end of conversion not cleared");
  a_open_cmp: assert property (cv.done |=>
    open_q == ($past(cv.result) > $past(open_thr_q)))
    else $error("open cable compare wrong");
  a_restore_pulse: assert property (ov_restore |=> !ov_restore)
    else $error("restore pulse too long");
  a_reserved_zero: assert property (!def_a_q[3] && def_b_q[3:2] == 2'b00)
    else $error("reserved default bits set");
  a_rx_priority: assert property (sw_q[6] |-> !sw_q[3] && !sw_q[0])
    else $error("serial pair overrides second ground sense");
endmodule
`default_nettype wire

/* tb/audio_mux_adc_default_regs_test.sv */
// Self-checking bench for the detection and default switch register bank
`timescale 1ns/10ps
`default_nettype none
module audio_mux_adc_default_regs_test;
  import amux_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic sample_valid = 1'b0;
  logic [7:0] sample = 8'h00;
  logic fsm_req = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, conv_active, c100, c1p1, c5p5;
  wire lowz_en, ov_restore, eoc_irq, open_cable, hs_alt;
  wire [1:0] bresp, rresp, ovth1, ovth2;
  wire [31:0] rdata;
  wire [15:0] sw;
  int error_cnt = 0;
  int checks_done = 0;
  int ov_cnt = 0;
  int thr_open;
  int thr_omtp;

  always #2 sys_clk = ~sys_clk;

  always @(posedge sys_clk) if (ov_restore === 1'b1) ov_cnt <= ov_cnt + 1;

  audio_mux_adc_default_regs #(.HAS_LEFT_SENSE(1'b1)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sample_valid(sample_valid), .sample(sample), .fsm_detect_req(fsm_req),
    .conv_active(conv_active), .current_100ua_en(c100), .current_1p1ma_en(c1p1),
    .current_5p5ma_en(c5p5), .low_impedance_check_en(lowz_en),
    .data_path_ov_threshold(ovth1), .sideband_path_ov_threshold(ovth2),
    .ov_restore(ov_restore), .eoc_irq(eoc_irq), .open_cable(open_cable),
    .headset_alt_wiring(hs_alt), .switch_close(sw)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    logic [1:0] rs;
    n = 0;
    @(posedge sys_clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(negedge sys_clk); while (!(awready && wready) && ++n < 50);
    @(posedge sys_clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge sys_clk); while (!bvalid && ++n < 50);
    rs = bresp;
    @(posedge sys_clk);
    bready <= 1'b0;
    if (n >= 50) error_cnt++;
    chk(rs, er);
  endtask

  task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge sys_clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge sys_clk); while (!arready && ++n < 50);
    @(posedge sys_clk);
    arvalid <= 1'b0;
    do @(negedge sys_clk); while (!rvalid && ++n < 50);
    d = rdata;
    rs = rresp;
    @(posedge sys_clk);
    rready <= 1'b0;
    if (n >= 50) error_cnt++;
  endtask

  task automatic rchk(input logic [5:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] rs;
    rd(idx, d, rs);
    chk(rs, RESP_OKAY);
    chk(d, {24'h00_0000, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] sw_model(input logic [7:0] a, input logic [7:0] b);
    logic [15:0] s;
    s[15] = a[7:6] == 2'b01;
    s[14] = a[7:6] == 2'b10;
    s[13] = a[5:4] == 2'b01;
    s[12] = a[5:4] == 2'b10;
    s[11] = !a[2] && a[0];
    s[10] = !a[2] && a[1];
    s[9] = a[2] && a[0];
    s[8] = a[2] && a[1];
    s[7:4] = {b[6], b[4], b[7], b[5]};
    s[3] = b[1:0] == 2'b01 && !b[4];
    s[2] = b[1:0] == 2'b01 && !b[6];
    s[1] = b[1:0] == 2'b10 && !b[6];
    s[0] = b[1:0] == 2'b10 && !b[4];
    return s;
  endfunction

  task automatic conv(input int mode, input int avg, input int detection_current);
    int nsmp, sum, res, n;
    logic [7:0] s;
    nsmp = (mode == 1) ? 1 : (2 << avg);
    sum = 0;
    n = 0;
    wr(IDX_ADC1, {4'h3, detection_current[1:0], mode[1:0]}, RESP_OKAY);
    wr(IDX_ADC2, {4'h9, avg[1:0], 2'b01}, RESP_OKAY);
    do @(negedge sys_clk); while (!conv_active && ++n < 50);
    @(negedge sys_clk);
    chk({c100, c1p1, c5p5}, detection_current < 2 ? 3'b100 : (detection_current == 2 ? 3'b010 : 3'b001));
    chk(lowz_en, 1'b1);
    repeat (nsmp) begin
      @(posedge sys_clk);
      s = 8'($urandom);
      sum += s;
      sample <= s;
      sample_valid <= 1'b1;
    end
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    res = sum / nsmp;
    do @(negedge sys_clk); while (!eoc_irq && ++n < 150);
    chk(eoc_irq, 1'b1);
    chk({hs_alt, open_cable}, {res < thr_omtp, res > thr_open});
    rchk(IDX_RESULT, res[7:0]);
    rchk(IDX_DETECT, {6'h00, res < thr_omtp, res > thr_open});
    rchk(IDX_ADC2, {4'h9, avg[1:0], 2'b00});
    rchk(IDX_STATUS, 8'h01);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    error_cnt++;
    give_verdict;
  end

  initial begin
    logic [7:0] a;
    logic [7:0] b;
    int c;
    void'($urandom(12981));
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    rchk(IDX_ADC2, 8'h90);
    rchk(IDX_OPEN_THR, 8'h0C);
    rchk(IDX_OMTP_THR, 8'h30);
    rchk(IDX_DEF_A, 8'h50);
    rchk(IDX_DEF_B, 8'h00);
    @(negedge sys_clk);
    chk(sw, 16'hA000);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr(IDX_ADC2, {i[1:0], ~i[1:0], 4'h0}, RESP_OKAY);
      chk({ovth1, ovth2}, {i[1:0], ~i[1:0]});
    end
    $display("test thresholds done");
    wr(IDX_DEF_A, 8'hFF, RESP_OKAY);
    rchk(IDX_DEF_A, 8'hF7);
    wr(IDX_DEF_B, 8'hFF, RESP_OKAY);
    rchk(IDX_DEF_B, 8'hF3);
    wr(6'h3F, 8'h55, RESP_SLVERR);
    rd(6'h3F, a, b[1:0]);
    chk({a, b[1:0]}, {8'h00, RESP_SLVERR});
    repeat (12) begin
      a = 8'($urandom);
      b = 8'($urandom);
      wr(IDX_DEF_A, a, RESP_OKAY);
      wr(IDX_DEF_B, b, RESP_OKAY);
      repeat (2) @(negedge sys_clk);
      chk(sw, sw_model(a & WMASK_DEF_A, b & WMASK_DEF_B));
    end
    wr(IDX_CTRL1, 8'h10, RESP_OKAY);
    repeat (2) @(negedge sys_clk);
    chk(sw, 16'h0000);
    wr(IDX_CTRL1, 8'h13, RESP_OKAY);
    $display("test defaults done");
    c = ov_cnt;
    wr(IDX_ADC2, 8'h92, RESP_OKAY);
    repeat (3) @(posedge sys_clk);
    chk(ov_cnt - c, 0);
    wr(IDX_CTRL1, 8'h1B, RESP_OKAY);
    wr(IDX_ADC2, 8'h92, RESP_OKAY);
    repeat (3) @(posedge sys_clk);
    chk(ov_cnt - c, 1);
    wr(IDX_CTRL1, 8'h13, RESP_OKAY);
    $display("test restore done");
    wr(IDX_ADC1, 8'h21, RESP_OKAY);
    @(negedge sys_clk);
    chk(lowz_en, 1'b0);
    wr(IDX_ADC1, 8'h30, RESP_OKAY);
    @(negedge sys_clk);
    chk(lowz_en, 1'b0);
    wr(IDX_ADC2, 8'h91, RESP_OKAY);
    c = 0;
    repeat (8) @(negedge sys_clk) c += conv_active;
    chk(c, 0);
    $display("test off mode done");
    thr_open = $urandom_range(255);
    thr_omtp = $urandom_range(255);
    wr(IDX_OPEN_THR, thr_open[7:0], RESP_OKAY);
    wr(IDX_OMTP_THR, thr_omtp[7:0], RESP_OKAY);
    wr(IDX_MASK, 8'h01, RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      conv(i == 0 ? 1 : 2, i == 0 ? 0 : i - 1, i % 4);
      wr(IDX_STATUS, 8'h01, RESP_OKAY);
    end
    conv(1, 0, 3);
    wr(IDX_MASK, 8'h00, RESP_OKAY);
    chk(eoc_irq, 1'b0);
    rchk(IDX_STATUS, 8'h01);
    wr(IDX_MASK, 8'h01, RESP_OKAY);
    chk(eoc_irq, 1'b1);
    wr(IDX_STATUS, 8'h01, RESP_OKAY);
    @(negedge sys_clk);
    chk(eoc_irq, 1'b0);
    $display("test conversions done");
    wr(IDX_ADC1, 8'h33, RESP_OKAY);
    @(posedge sys_clk);
    fsm_req <= 1'b1;
    c = 0;
    do @(negedge sys_clk); while (!conv_active && ++c < 50);
    chk(conv_active, 1'b1);
    @(posedge sys_clk);
    fsm_req <= 1'b0;
    sample <= 8'h40;
    sample_valid <= 1'b1;
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rchk(IDX_RESULT, 8'h40);
    chk({hs_alt, open_cable}, {64 < thr_omtp, 64 > thr_open});
    rchk(IDX_STATUS, 8'h00);
    $display("test auto mode done");
    give_verdict;
  end
endmodule
`default_nettype wire
